// ===== core/vic_ctrl.sv
// vectored priority interrupt unit with ahb-lite register slave
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
module vic_ctrl
  import vic_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt pins
  input wire logic [vic_pkg::VIC_LEVELS-1:0] request_lines_n,
  input wire logic cascade_n,
  input wire logic interrupt_acknowledge_state,
  output logic interrupt_n,
  output logic irq
);
  import vic_pkg::*;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [VIC_LEVELS+1:0] pin_level;
  logic [VIC_LEVELS+1:0] pin_fall;
  logic [VIC_LEVELS-1:0] req_fall;
  logic cascade_lvl_n;
  logic ack_rise;

  // acknowledge is inverted ahead of the synchroniser so its rise shows as a fall
  vic_edge_sync #(.WIDTH(VIC_LEVELS + 2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin({~interrupt_acknowledge_state, cascade_n, request_lines_n}),
    .level(pin_level),
    .fall(pin_fall)
  );
  assign req_fall = pin_fall[VIC_LEVELS-1:0];
  assign cascade_lvl_n = pin_level[VIC_LEVELS];
  assign ack_rise = pin_fall[VIC_LEVELS+1];

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] page, next_page;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] mask, next_mask;
  logic [VIC_LEVELS-1:0] pending, next_pending;
  logic [VIC_EVT_W-1:0] evt_stat, next_evt_stat;
  logic [VIC_EVT_W-1:0] evt_mask, next_evt_mask;
  vic_vec_e vstate, next_vstate;
  logic [VIC_LVL_W-1:0] held_lvl, next_held_lvl;
  logic dp_wr, next_dp_wr;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic next_interrupt_n;
  logic next_irq;

  // ****************************************************************
  // priority and vector byte
  // ****************************************************************
  logic [VIC_LEVELS-1:0] active;
  logic any_active;
  logic [VIC_LVL_W-1:0] top_lvl;

  assign active = pending & ~mask;

  always_comb begin
    any_active = 1'b0;
    top_lvl = '0;
    for (int i = 0; i < VIC_LEVELS; i++) begin
      if (active[i]) begin
        any_active = 1'b1;
        top_lvl = VIC_LVL_W'(i);
      end
    end
  end

  function automatic logic [7:0] low_byte(input logic [7:0] c, input logic [VIC_LVL_W-1:0] lvl);
    logic [1:0] code;
    logic [7:0] hi_keep;
    code = c[VIC_CTRL_INT_POS:0];
    hi_keep = 8'((9'h1ff << (code + 3'h4)));
    low_byte = ({c[7:VIC_CTRL_HI_POS], 4'h0} & hi_keep)
      | 8'({5'h0, lvl} << (code + 3'h1));
  endfunction

  // ****************************************************************
  // ahb address phase and read data
  // ****************************************************************
  logic ap_valid;
  logic ap_read;
  logic rd_status;
  logic rd_vector;
  logic wr_apply;

  assign ap_valid = hsel & hready & (htrans == VIC_HTRANS_NONSEQ | htrans == VIC_HTRANS_SEQ);
  assign ap_read = ap_valid & ~hwrite;
  assign rd_status = ap_read & (haddr == VIC_STATUS_OFS);
  assign rd_vector = ap_read & (haddr == VIC_VECTOR_OFS);
  assign wr_apply = dp_wr;

  always_comb begin
    next_dp_wr = ap_valid & hwrite;
    next_dp_addr = ap_valid ? haddr : dp_addr;
    next_hrdata = '0;
    if (ap_read) begin
      unique case (haddr)
        VIC_STATUS_OFS: next_hrdata = {24'h0, pending};
        VIC_POLL_OFS: next_hrdata = {24'h0, low_byte(ctrl, top_lvl)};
        VIC_EVT_STAT_OFS: next_hrdata = {30'h0, evt_stat};
        VIC_EVT_MASK_OFS: next_hrdata = {30'h0, evt_mask};
        VIC_VECTOR_OFS: begin
          unique case (vstate)
            VIC_V_ARMED: next_hrdata = {24'h0, VIC_LBR_OPCODE};
            VIC_V_PAGE: next_hrdata = {24'h0, page};
            VIC_V_LOW: next_hrdata = {24'h0, low_byte(ctrl, held_lvl)};
            default: next_hrdata = '0;
          endcase
        end
        default: next_hrdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // acknowledge fetch sequence
  // ****************************************************************
  logic [VIC_LEVELS-1:0] ack_clr;
  logic held_valid, next_held_valid;

  always_comb begin
    next_vstate = vstate;
    next_held_lvl = held_lvl;
    next_held_valid = held_valid;
    ack_clr = '0;
    unique case (vstate)
      VIC_V_IDLE: begin
        if (ack_rise) begin
          next_vstate = VIC_V_ARMED;
        end
      end
      VIC_V_ARMED: begin
        if (rd_vector) begin
          // level frozen here so vector and cleared latch agree
          next_held_lvl = top_lvl;
          next_held_valid = any_active;
          ack_clr = any_active ? (VIC_LEVELS'(1) << top_lvl) : '0;
          next_vstate = VIC_V_PAGE;
        end
      end
      VIC_V_PAGE: begin
        if (rd_vector) begin
          next_vstate = VIC_V_LOW;
        end
      end
      VIC_V_LOW: begin
        if (rd_vector) begin
          next_vstate = VIC_V_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // registers, latches and interrupt outputs
  // ****************************************************************
  logic mir_pulse;
  logic mmr_pulse;
  logic [VIC_EVT_W-1:0] evt_set;
  logic [VIC_EVT_W-1:0] evt_clr;

  assign mir_pulse = wr_apply & (dp_addr == VIC_CTRL_OFS) & ~hwdata[VIC_CTRL_MIR_POS];
  assign mmr_pulse = wr_apply & (dp_addr == VIC_CTRL_OFS) & ~hwdata[VIC_CTRL_MMR_POS];
  assign evt_set = {rd_vector & (vstate == VIC_V_LOW), |req_fall};
  assign evt_clr = (wr_apply & (dp_addr == VIC_EVT_STAT_OFS)) ? hwdata[VIC_EVT_W-1:0] : '0;

  always_comb begin
    next_page = page;
    next_ctrl = ctrl;
    next_mask = mask;
    next_evt_mask = evt_mask;
    if (wr_apply) begin
      unique case (dp_addr)
        VIC_PAGE_OFS: next_page = hwdata[7:0];
        VIC_CTRL_OFS: next_ctrl = hwdata[7:0];
        VIC_MASK_OFS: next_mask = hwdata[7:0];
        VIC_EVT_MASK_OFS: next_evt_mask = hwdata[VIC_EVT_W-1:0];
        default: next_mask = mask;
      endcase
    end
    if (mmr_pulse) begin
      next_mask = '0;
    end
    // a fresh edge wins over any clear in the same cycle
    next_pending = pending & ~ack_clr;
    if (rd_status || mir_pulse) begin
      next_pending = '0;
    end
    next_pending = next_pending | req_fall;
    next_evt_stat = (evt_stat & ~evt_clr) | evt_set;
    // cascade low means a chained unit is requesting through us
    next_interrupt_n = ~(|(next_pending & ~next_mask)) & cascade_lvl_n;
    next_irq = |(next_evt_stat & next_evt_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page <= VIC_PAGE_RST;
      ctrl <= VIC_CTRL_RST;
      mask <= VIC_MASK_RST;
      pending <= '0;
      evt_stat <= '0;
      evt_mask <= '0;
      vstate <= VIC_V_IDLE;
      held_lvl <= '0;
      held_valid <= 1'b0;
      dp_wr <= 1'b0;
      dp_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      interrupt_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      page <= next_page;
      ctrl <= next_ctrl;
      mask <= next_mask;
      pending <= next_pending;
      evt_stat <= next_evt_stat;
      evt_mask <= next_evt_mask;
      vstate <= next_vstate;
      held_lvl <= next_held_lvl;
      held_valid <= next_held_valid;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      interrupt_n <= next_interrupt_n;
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // every line that showed an edge must be pending one cycle later
  edge_latches_a: assert property (|req_fall |=> &(pending | ~$past(req_fall)))
    else $error("edge not latched");
  // the output is registered from the next latch value, so it tracks pending in the same cycle
  int_low_a: assert property (|(pending & ~mask) |-> !interrupt_n)
    else $error("int not low");
  masked_quiet_a: assert property (cascade_lvl_n && (pending & ~mask) == '0
    && !(|req_fall) && !wr_apply |=> interrupt_n) else $error("masked request interrupted");
  opcode_first_a: assert property (vstate == VIC_V_ARMED && rd_vector
    |=> hrdata[7:0] == VIC_LBR_OPCODE) else $error("opcode wrong");
  page_second_a: assert property (vstate == VIC_V_PAGE && rd_vector
    |=> hrdata[7:0] == $past(page)) else $error("page byte wrong");
  serviced_clear_a: assert property (vstate == VIC_V_ARMED && rd_vector && any_active
    && !req_fall[top_lvl] && !wr_apply |=> !pending[$past(top_lvl)])
    else $error("latch kept");
  status_clear_a: assert property (rd_status && req_fall == '0 |=> pending == '0)
    else $error("status read kept latches");
  status_shows_a: assert property (rd_status |=> hrdata[7:0] == $past(pending))
    else $error("status wrong");
  top_level_a: assert property (any_active |-> (active >> top_lvl) == VIC_LEVELS'(1))
    else $error("priority wrong");
  held_level_a: assert property (vstate != VIC_V_ARMED |=> held_lvl == $past(held_lvl))
    else $error("held level moved");
  cascade_pass_a: assert property (!cascade_lvl_n |=> !interrupt_n)
    else $error("cascade lost");

  seq_done_c: cover property (vstate == VIC_V_LOW && rd_vector);
  status_rd_c: cover property (rd_status && pending != '0);
  masked_req_c: cover property (|(req_fall & mask));
  irq_c: cover property (irq);
endmodule

// ===== core/vic_pkg.sv
// package: register map, field layout and constants of the vectored interrupt unit
package vic_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] VIC_PAGE_OFS = 8'h00;
  localparam logic [7:0] VIC_CTRL_OFS = 8'h04;
  localparam logic [7:0] VIC_MASK_OFS = 8'h08;
  localparam logic [7:0] VIC_STATUS_OFS = 8'h0c;
  localparam logic [7:0] VIC_POLL_OFS = 8'h10;
  localparam logic [7:0] VIC_VECTOR_OFS = 8'h14;
  localparam logic [7:0] VIC_EVT_STAT_OFS = 8'h18;
  localparam logic [7:0] VIC_EVT_MASK_OFS = 8'h1c;
  // ****************************************************************
  // fields and values
  // ****************************************************************
  localparam int VIC_LEVELS = 8;
  localparam int VIC_LVL_W = 3;
  localparam int VIC_CTRL_INT_POS = 1;
  localparam int VIC_CTRL_MIR_POS = 3;
  localparam int VIC_CTRL_MMR_POS = 2;
  localparam int VIC_CTRL_HI_POS = 4;
  localparam logic [7:0] VIC_LBR_OPCODE = 8'hc0;
  localparam logic [7:0] VIC_PAGE_RST = 8'h00;
  localparam logic [7:0] VIC_CTRL_RST = 8'h0c;
  localparam logic [7:0] VIC_MASK_RST = 8'h00;
  localparam int VIC_EVT_W = 2;
  localparam int VIC_EVT_REQ = 0;
  localparam int VIC_EVT_DONE = 1;
  localparam int VIC_SYNC_STAGES = 2;
  localparam logic [1:0] VIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] VIC_HTRANS_SEQ = 2'h3;
  typedef enum logic [3:0] {
    VIC_V_IDLE = 4'h1,
    VIC_V_ARMED = 4'h2,
    VIC_V_PAGE = 4'h4,
    VIC_V_LOW = 4'h8
  } vic_vec_e;
endpackage

// ===== core/vic_edge_sync.sv
// per-line two-stage synchroniser with falling-edge detection
`timescale 1ns/10ps
module vic_edge_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // lines from pins
  input wire logic [WIDTH-1:0] pin,
  // synchronised level and falling-edge pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      // idle lines sit high, so reset to one to avoid a false edge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i] <= 1'b1;
          level[i] <= 1'b1;
          prev[i] <= 1'b1;
          fall[i] <= 1'b0;
        end else begin
          meta[i] <= pin[i];
          level[i] <= meta[i];
          prev[i] <= level[i];
          fall[i] <= prev[i] & ~level[i];
        end
      end
    end
  endgenerate
endmodule

// ===== test/vic_cpu_model.sv
// processor-side model: takes the interrupt and runs the acknowledge state
`timescale 1ns/10ps
module vic_cpu_model (
  // clock
  input wire logic hclk,
  // interrupt handshake
  input wire logic interrupt_n,
  input wire logic take_int,
  output logic interrupt_acknowledge_state
);
  int hold;
  initial interrupt_acknowledge_state = 1'b0;
  initial hold = 0;
  // ****************************************************************
  // acknowledge cycle
  // ****************************************************************
  // a real processor acknowledges only while its interrupt input is low,
  // so a bench request with nothing pending is simply ignored
  always @(posedge hclk) begin
    if (interrupt_acknowledge_state) begin
      if (hold == 1) begin
        interrupt_acknowledge_state <= 1'b0;
      end
      hold <= hold - 1;
    end else if (take_int && interrupt_n === 1'b0) begin
      interrupt_acknowledge_state <= 1'b1;
      hold <= 3;
    end
  end
endmodule

// ===== test/vic_ctrl_tb.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
module vic_ctrl_tb;
  import vic_pkg::*;
  localparam logic [7:0] PAGE = 8'h5a;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic cascade_n, interrupt_n, irq, take_int, ack_state;
  logic [7:0] haddr, request_lines_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] row_ctrl [4] = '{8'hac, 8'h3d, 8'hfe, 8'h8f};
  int row_lvl [4] = '{7, 0, 5, 3};
  logic [7:0] row_lo [4] = '{8'hae, 8'h20, 8'he8, 8'hb0};
  int n_mismatch, checks;

  vic_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .request_lines_n(request_lines_n), .cascade_n(cascade_n),
    .interrupt_acknowledge_state(ack_state), .interrupt_n(interrupt_n), .irq(irq));
  vic_cpu_model cpu (.hclk(hclk), .interrupt_n(interrupt_n), .take_int(take_int),
    .interrupt_acknowledge_state(ack_state));

  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= VIC_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // pulse the given lines low; long enough for both sync stages to see it
  task automatic req(input logic [7:0] lines);
    @(posedge hclk);
    request_lines_n <= ~lines;
    repeat (3) @(posedge hclk);
    request_lines_n <= 8'hff;
    repeat (5) @(posedge hclk);
  endtask

  // expected low byte is worked out by hand from the control byte and the level
  task automatic vec(input logic [7:0] lo);
    @(posedge hclk);
    take_int <= 1'b1;
    @(posedge hclk);
    take_int <= 1'b0;
    repeat (6) @(posedge hclk);
    ahb(1'b0, VIC_VECTOR_OFS, 32'h0);
    check("opcode", rd, {24'h0, VIC_LBR_OPCODE});
    ahb(1'b0, VIC_VECTOR_OFS, 32'h0);
    check("page", rd, {24'h0, PAGE});
    ahb(1'b0, VIC_VECTOR_OFS, 32'h0);
    check("low vector", rd, {24'h0, lo});
    repeat (2) @(posedge hclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    request_lines_n = 8'hff;
    cascade_n = 1'b1;
    take_int = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("reset int", interrupt_n, 1'b1);
    check("reset irq", irq, 1'b0);
    check("reset rdata", hrdata, 32'h0);
    ahb(1'b1, VIC_PAGE_OFS, {24'h0, PAGE});
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, VIC_CTRL_OFS, {24'h0, row_ctrl[i]});
      req(8'h01 << row_lvl[i]);
      check("int low", interrupt_n, 1'b0);
      vec(row_lo[i]);
      check("int released", interrupt_n, 1'b1);
      ahb(1'b0, VIC_STATUS_OFS, 32'h0);
      check("served cleared", rd, 32'h0);
      check("resp okay", hresp, 1'b0);
    end
    // two pending: the higher line is served first, the lower keeps the output low
    req(8'h44);
    vec(8'he0);
    check("int held", interrupt_n, 1'b0);
    vec(8'ha0);
    check("int second release", interrupt_n, 1'b1);
    ahb(1'b1, VIC_MASK_OFS, 32'h10);
    req(8'h10);
    check("masked int", interrupt_n, 1'b1);
    ahb(1'b0, VIC_STATUS_OFS, 32'h0);
    check("status masked", rd, 32'h10);
    ahb(1'b0, VIC_STATUS_OFS, 32'h0);
    check("status cleared", rd, 32'h0);
    ahb(1'b1, VIC_MASK_OFS, 32'h0);
    req(8'h81);
    ahb(1'b0, VIC_STATUS_OFS, 32'h0);
    check("status both", rd, 32'h81);
    repeat (3) @(posedge hclk);
    check("int after clear", interrupt_n, 1'b1);
    // control bit2 low clears the mask, bit3 low drops every latch
    ahb(1'b1, VIC_MASK_OFS, 32'h08);
    req(8'h08);
    check("masked again", interrupt_n, 1'b1);
    ahb(1'b1, VIC_CTRL_OFS, 32'h8b);
    repeat (2) @(posedge hclk);
    check("mask reset", interrupt_n, 1'b0);
    ahb(1'b0, VIC_POLL_OFS, 32'h0);
    check("poll", rd, 32'hb0);
    ahb(1'b1, VIC_CTRL_OFS, 32'h04);
    repeat (2) @(posedge hclk);
    check("latch reset", interrupt_n, 1'b1);
    ahb(1'b0, VIC_STATUS_OFS, 32'h0);
    check("latch reset status", rd, 32'h0);
    @(posedge hclk);
    cascade_n <= 1'b0;
    repeat (5) @(posedge hclk);
    check("cascade low", interrupt_n, 1'b0);
    cascade_n <= 1'b1;
    repeat (5) @(posedge hclk);
    check("cascade high", interrupt_n, 1'b1);
    ahb(1'b1, VIC_EVT_MASK_OFS, 32'h3);
    repeat (2) @(posedge hclk);
    check("irq raised", irq, 1'b1);
    ahb(1'b1, VIC_EVT_STAT_OFS, 32'h3);
    repeat (2) @(posedge hclk);
    check("irq cleared", irq, 1'b0);
    req(8'h02);
    check("irq edge", irq, 1'b1);
    ahb(1'b1, VIC_EVT_MASK_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    check("irq masked", irq, 1'b0);
    // reset in mid-run must drop the pending line left by the last request
    check("pre reset int", interrupt_n, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("reset2 int", interrupt_n, 1'b1);
    check("reset2 irq", irq, 1'b0);
    ahb(1'b0, VIC_STATUS_OFS, 32'h0);
    check("reset2 status", rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    finish_test();
  end
endmodule
